// File: rtl/embc_ctrl.sv
`timescale 1ns/10ps
module embc_ctrl
  import embc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_mux_select,
  input wire logic i_ext_access_select,
  input wire logic i_strobe_suppress_bit,
  input wire logic i_req_valid,
  input wire embc_req_s i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output embc_rsp_s o_rsp,
  output logic o_addr_latch_strobe,
  output logic o_prog_store_strobe,
  output logic o_demux_mode,
  input wire logic [7:0] i_shared_bus_in,
  output logic [7:0] o_shared_bus_out,
  output logic [7:0] o_shared_bus_oe_n
);

  // ---------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------
  logic [2:0] mux_sync_q;
  logic [2:0] access_sync_q;
  logic [7:0] bus_s1_q;
  logic [7:0] bus_s2_q;
  logic [7:0] bus_s3_q;
  logic access_q;

  // Three stages per pin; the first stage feeds only the second.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mux_sync_q <= 3'h0;
      access_sync_q <= 3'h0;
      bus_s1_q <= BUS_IDLE;
      bus_s2_q <= BUS_IDLE;
      bus_s3_q <= BUS_IDLE;
    end else begin
      mux_sync_q <= {mux_sync_q[1:0], i_bus_mux_select};
      access_sync_q <= {access_sync_q[1:0], i_ext_access_select};
      bus_s1_q <= i_shared_bus_in;
      bus_s2_q <= bus_s1_q;
      bus_s3_q <= bus_s2_q;
    end
  end

  // The access select level counts once the later two stages agree.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      access_q <= 1'b0;
    end else if (access_sync_q[1] == access_sync_q[2]) begin
      access_q <= access_sync_q[2];
    end
  end

  // ---------------------------------------------------------------------
  // Bus mode capture.
  // ---------------------------------------------------------------------
  logic [1:0] fill_q;
  logic mode_valid_q;
  logic demux_q;

  // The mode is caught once, after release, when the pipeline is full and
  // settled; later changes on the pin are ignored until the next reset.
  // sample once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_q <= 2'h0;
      mode_valid_q <= 1'b0;
      demux_q <= 1'b0;
    end else if (!mode_valid_q) begin
      if (fill_q != SYNC_FULL) begin
        fill_q <= fill_q + 2'h1;
      end else if (mux_sync_q[1] == mux_sync_q[2]) begin
        mode_valid_q <= 1'b1;
        demux_q <= (mux_sync_q[2] != BUS_MODE_MUX);
      end
    end
  end

  assign o_demux_mode = demux_q;

  // ---------------------------------------------------------------------
  // Strobe phase counter.
  // ---------------------------------------------------------------------
  logic [2:0] ph_q;

  // Each clock is half an oscillator cycle, so 1.5 cycles is three phases.
  // doubled reference
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_q <= 3'h0;
    end else if (ph_q == PH_LAST) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= ph_q + 3'h1;
    end
  end

  // Strobe output is registered; forced high in reset and when suppressed in demux mode.
  // pulse timing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_addr_latch_strobe <= 1'b1;
    end else if (demux_q && i_strobe_suppress_bit) begin
      o_addr_latch_strobe <= 1'b1;
    end else begin
      o_addr_latch_strobe <= (ph_q == PH_LAST) || (ph_q < PH_HIGH - 3'h1);
    end
  end

  // ---------------------------------------------------------------------
  // Access sequencer.
  // ---------------------------------------------------------------------
  embc_state_e state_q;
  embc_req_s req_q;
  logic start;
  logic internal_fetch;

  // A request is taken in the last phase so the access lines up with the
  // next strobe pulse.
  assign o_req_ready = mode_valid_q && (state_q == EMBC_IDLE) && (ph_q == PH_LAST);
  assign start = i_req_valid && o_req_ready;
  assign internal_fetch = i_req.is_code && access_q;

  // Sequencer state; internal fetches never occupy the external bus.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= EMBC_IDLE;
      req_q <= '0;
    end else begin
      case (state_q)
        EMBC_IDLE: begin
          if (start && !internal_fetch) begin
            req_q <= i_req;
            state_q <= i_req.write ? EMBC_WRITE : EMBC_READ;
          end
        end
        EMBC_READ, EMBC_WRITE: begin
          if (ph_q == PH_LAST) begin
            state_q <= EMBC_IDLE;
          end
        end
        default: begin
          state_q <= EMBC_IDLE;
        end
      endcase
    end
  end

  // Answer pulse; read data is the settled synchronised bus.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp <= '0;
    end else begin
      o_rsp_valid <= 1'b0;
      if (start && internal_fetch) begin
        o_rsp_valid <= 1'b1;
        o_rsp <= '{rdata: 8'h00, internal: 1'b1};
      end else if (state_q != EMBC_IDLE && ph_q == PH_LAST) begin
        o_rsp_valid <= 1'b1;
        o_rsp <= '{rdata: (state_q == EMBC_READ) ? bus_s3_q : 8'h00, internal: 1'b0};
      end
    end
  end

  // Program store strobe: low only in the data phases of a code read.
  // active-low enable
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prog_store_strobe <= 1'b1;
    end else begin
      o_prog_store_strobe <= !((state_q == EMBC_READ) && req_q.is_code &&
                               (ph_q >= PH_DATA - 3'h1) && (ph_q < PH_STRB_END));
    end
  end

  // ---------------------------------------------------------------------
  // Port 0 drivers.
  // ---------------------------------------------------------------------
  logic addr_phase;
  logic data_phase;

  // Outputs are registered, so these decode the phase one clock ahead.
  assign addr_phase = (state_q != EMBC_IDLE) && (ph_q < PH_HIGH - 3'h1);
  assign data_phase = (ph_q >= PH_DATA - 3'h1) && (ph_q != PH_LAST);

  // Port 0 idles driven high; there is no software path to it. The phase
  // after the strobe falls has no driver change from address to data, so
  // the two never overlap on the pins.
  // reset high
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_shared_bus_out <= BUS_IDLE;
      o_shared_bus_oe_n <= 8'h00;
    end else if (start && !internal_fetch) begin
      // The address must already stand in the first strobe-high cycle.
      o_shared_bus_out <= demux_q ? BUS_IDLE : i_req.addr_low;
      o_shared_bus_oe_n <= demux_q ? 8'h00_ff : 8'h00;
    end else if (addr_phase && !demux_q) begin
      o_shared_bus_out <= req_q.addr_low;
      o_shared_bus_oe_n <= 8'h00;
    end else if ((state_q == EMBC_WRITE) && data_phase) begin
      o_shared_bus_out <= req_q.wdata;
      o_shared_bus_oe_n <= 8'h00;
    end else if (state_q != EMBC_IDLE) begin
      o_shared_bus_out <= BUS_IDLE;
      o_shared_bus_oe_n <= 8'h00_ff;
    end else begin
      o_shared_bus_out <= BUS_IDLE;
      o_shared_bus_oe_n <= 8'h00;
    end
  end

endmodule : embc_ctrl

// File: rtl/embc_pkg.sv
package embc_pkg;

  // ---------------------------------------------------------------------
  // Timing, counted in half cycles of the oscillator input.
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  // The logic clock runs at twice the oscillator input rate.
  localparam int unsigned OSC_HZ = CLK_HZ / 2;
  // Strobe period is four oscillator cycles.
  localparam int unsigned STROBE_PERIOD_OSC = 4;
  // Strobe high time is 1.5 oscillator cycles, three half cycles.
  localparam int unsigned STROBE_HIGH_HALF = 3;
  localparam int unsigned STROBE_PERIOD_HALF = STROBE_PERIOD_OSC * CLK_HZ / OSC_HZ;
  localparam logic [2:0] PH_LAST = 3'(STROBE_PERIOD_HALF - 1);
  localparam logic [2:0] PH_HIGH = 3'(STROBE_HIGH_HALF);
  // Write data is driven one half cycle after the strobe falls; address drivers are released as it falls.
  localparam logic [2:0] PH_DATA = 3'(STROBE_HIGH_HALF + 1);
  // The program store strobe stays low up to this phase.
  localparam logic [2:0] PH_STRB_END = 3'(STROBE_PERIOD_HALF - 2);

  // ---------------------------------------------------------------------
  // Reset values and bus encodings.
  // ---------------------------------------------------------------------
  localparam logic [7:0] BUS_IDLE = 8'h00_ff;
  localparam logic BUS_MODE_MUX = 1'b0;
  localparam logic [1:0] SYNC_FULL = 2'h3;

  // A request from the core toward external memory.
  typedef struct packed {
    logic [7:0] addr_low;
    logic is_code;
    logic write;
    logic [7:0] wdata;
  } embc_req_s;

  // The answer handed back to the core.
  typedef struct packed {
    logic [7:0] rdata;
    logic internal;
  } embc_rsp_s;

  typedef enum logic [1:0] {
    EMBC_IDLE = 2'b00,
    EMBC_READ = 2'b01,
    EMBC_WRITE = 2'b10
  } embc_state_e;

endpackage : embc_pkg

// File: testbench/embc_mem_model.sv
`timescale 1ns/10ps
// ----
// External address latch and memory on port 0.
// ----
module embc_mem_model (
  input wire logic i_clk,
  input wire logic i_strobe,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe_n,
  input wire logic i_slow,
  output logic [7:0] o_level
);
  logic [7:0] latch_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [1:0] wait_q = 2'h0;
  logic drive;
  // latch follows strobe. Sampled on the clock to avoid a race at the fall.
  always_ff @(posedge i_clk) begin
    if (i_strobe) latch_q <= o_level;
  end
  // Counts released cycles, so a slow memory answers one cycle late.
  always_ff @(posedge i_clk) begin
    wait_q <= (i_oe_n[0] && !i_strobe) ? ((wait_q == 2'h3) ? wait_q : wait_q + 2'h1) : 2'h0;
    last_q <= o_level;
  end
  assign drive = i_oe_n[0] && !i_strobe && (wait_q >= {1'b0, i_slow});
  // An undriven bus shows the inverse of its last level, never a stale copy.
  assign o_level = (~i_oe_n & i_out) | (i_oe_n & (drive ? latch_q ^ 8'h3c : ~last_q));
endmodule : embc_mem_model

// File: testbench/embc_ctrl_asserts.sv
`timescale 1ns/10ps
// ----
// Port checks of the bus controller.
// ----
module embc_ctrl_asserts
  import embc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_strobe_suppress_bit,
  input wire logic i_req_valid,
  input wire embc_req_s i_req,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic o_addr_latch_strobe,
  input wire logic o_prog_store_strobe,
  input wire logic o_demux_mode,
  input wire logic [7:0] o_shared_bus_out,
  input wire logic [7:0] o_shared_bus_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // A data read taken on this edge.
  wire data_rd = i_req_valid && o_req_ready && !i_req.is_code && !i_req.write;
  strobe_shape_a: assert property ($rose(o_addr_latch_strobe) && !o_demux_mode
    |-> o_addr_latch_strobe[*3] ##1 !o_addr_latch_strobe) else $error("strobe width");
  // A fall that ends a suppressed stretch cleared in phases 3 to 6 is off the phase grid, so only
  // falls that follow a full low stretch are held to the period.
  strobe_return_a: assert property ($fell(o_addr_latch_strobe) && !$past(o_addr_latch_strobe, 4)
    |-> ##5 o_addr_latch_strobe) else $error("strobe period");
  suppress_high_a: assert property (o_demux_mode && i_strobe_suppress_bit
    |=> o_addr_latch_strobe) else $error("strobe not held");
  store_pulse_a: assert property ($fell(o_prog_store_strobe)
    |-> !o_prog_store_strobe[*3] ##1 o_prog_store_strobe) else $error("store strobe pulse");
  addr_on_bus_a: assert property (data_rd && !o_demux_mode |=> o_shared_bus_oe_n == 8'h00
    && o_shared_bus_out == $past(i_req.addr_low)) else $error("address missing");
  bus_turn_a: assert property (data_rd && !o_demux_mode
    |-> ##4 o_shared_bus_oe_n == 8'hff && !o_addr_latch_strobe) else $error("turn late");
  demux_data_a: assert property (i_req_valid && o_req_ready && o_demux_mode
    && !i_req.is_code |=> o_shared_bus_oe_n == 8'hff) else $error("address in demux");
  data_answer_a: assert property (data_rd |-> ##9 o_rsp_valid) else $error("answer late");
  cover property (i_req_valid && o_req_ready && i_req.write);
  cover property (o_demux_mode && i_strobe_suppress_bit);
  cover property ($fell(o_prog_store_strobe));
endmodule : embc_ctrl_asserts

bind embc_ctrl embc_ctrl_asserts i_embc_ctrl_asserts (.*);

// File: testbench/test_ext_memory_bus_control.sv
`timescale 1ns/10ps
module test_ext_memory_bus_control;
  import embc_pkg::*;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_bus_mux_select = 1'h0, i_ext_access_select = 1'h0;
  logic i_strobe_suppress_bit = 1'h0, i_req_valid = 1'h0, mem_slow = 1'h0;
  embc_req_s i_req = '0;
  logic o_req_ready, o_rsp_valid, o_addr_latch_strobe, o_prog_store_strobe, o_demux_mode;
  embc_rsp_s o_rsp;
  logic [7:0] i_shared_bus_in, o_shared_bus_out, o_shared_bus_oe_n;
  int error_cnt = 0, n_compared = 0;
  // Half period of a 20 ns clock.
  always #10 i_clk = ~i_clk;
  embc_ctrl i_embc_ctrl (.*);
  embc_mem_model i_embc_mem_model (.i_clk, .i_strobe(o_addr_latch_strobe),
    .i_out(o_shared_bus_out), .i_oe_n(o_shared_bus_oe_n), .i_slow(mem_slow),
    .o_level(i_shared_bus_in));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compared %0d bad %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Bounded wait on ready (0) or answer (1); a hang ends the run.
  task automatic wait_hi(input bit sel, input int n);
    int k;
    for (k = 0; k < n && (sel ? o_rsp_valid : o_req_ready) !== 1'h1; k++) @(negedge i_clk);
    if (k == n) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  endtask : wait_hi
  task automatic t_reset(input logic m);
    @(posedge i_clk);
    #2 i_rst_n = 1'h0;
    i_bus_mux_select = m;
    repeat (8) @(negedge i_clk);
    chk(o_addr_latch_strobe, 9'h1);
    chk(o_prog_store_strobe, 9'h1);
    chk({o_shared_bus_out, 1'h0}, 9'h1fe);
    chk(o_shared_bus_oe_n, 9'h0);
    @(posedge i_clk);
    #2 i_rst_n = 1'h1;
    repeat (12) @(negedge i_clk);
    chk(o_demux_mode, m);
    $display("reset test done");
  endtask : t_reset
  task automatic xfer(input embc_req_s r, input logic [8:0] exp);
    @(posedge i_clk);
    #2 i_req = r;
    i_req_valid = 1'h1;
    wait_hi(1'b0, 40);
    @(posedge i_clk);
    #2 i_req_valid = 1'h0;
    if (r.write) begin
      repeat (5) @(negedge i_clk);
      chk(o_shared_bus_out, r.wdata);
      chk(o_shared_bus_oe_n, 9'h0);
    end else begin
      wait_hi(1'b1, 12);
      chk(o_rsp, exp);
    end
  endtask : xfer
  task automatic t_mux;
    xfer('{8'ha5, 1'h1, 1'h0, 8'h00}, {8'h99, 1'h0});
    mem_slow = 1'h1;
    xfer('{8'h00, 1'h0, 1'h0, 8'h00}, {8'h3c, 1'h0});
    mem_slow = 1'h0;
    xfer('{8'hff, 1'h0, 1'h1, 8'h5a}, 9'h0);
    @(posedge i_clk);
    #2 i_ext_access_select = 1'h1;
    repeat (5) @(posedge i_clk);
    xfer('{8'h12, 1'h1, 1'h0, 8'h00}, 9'h1);
    i_ext_access_select = 1'h0;
    $display("multiplexed test done");
  endtask : t_mux
  task automatic t_demux;
    int k, n;
    t_reset(1'h1);
    @(posedge i_clk);
    #2 i_bus_mux_select = 1'h0;
    i_strobe_suppress_bit = 1'h1;
    n = 0;
    for (k = -2; k < 16; k++) begin
      @(negedge i_clk);
      if (k >= 0) n += int'(o_addr_latch_strobe);
    end
    chk(9'(n), 9'd16);
    @(posedge i_clk);
    #2 i_strobe_suppress_bit = 1'h0;
    n = 0;
    for (k = -2; k < 16; k++) begin
      @(negedge i_clk);
      if (k >= 0) n += int'(o_addr_latch_strobe);
    end
    chk(9'(n), 9'd6);
    chk(o_demux_mode, 9'h1);
    xfer('{8'h44, 1'h0, 1'h1, 8'hc3}, 9'h0);
    $display("demultiplexed test done");
  endtask : t_demux
  initial begin
    t_reset(1'h0);
    t_mux();
    t_demux();
    report_and_stop();
  end
endmodule : test_ext_memory_bus_control
